// >>> rtl/rcr_reset_unit.sv
// Device end: reset sources, cause status, retention controls and unlock key
// What this block does
// - Four sources: pin, power-on, watchdog, software
// - Software reset needs 0x05FA in upper half
// - Analog state kept across soft resets by default
// - Pins and logic array kept; 0x1 resets them
// - Pin config write accepted only after two key words; analog config needs no key
// - Software writes config immediately after second key
// - Any other write relocks the key
// - Cause kept until software or a power-on reset clears it
// - Bits 3,2,1,0 soft,watchdog,pin,power-on; W1C
// - Analog bit0: 0 keeps, 1 resets
// - With retention, only pin/power-on clear retained state
// - Watchdog enabled after reset, about 32 seconds
// - Software should disable watchdog when not needed
`timescale 1ns/100ps
module rcr_reset_unit #(
   parameter longint WdogTimeoutCycles = rcr_pkg::WDOG_TIMEOUT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   rcr_if.device bus,
   input wire logic powerOnReset_n,
   input wire logic pinReset_n,
   input wire logic watchdogDisable,
   input wire logic watchdogKick,
   output logic systemReset,
   output logic retainedReset,
   output logic pinLogicReset,
   output logic analogDieReset,
   output logic sramValid,
   output logic watchdogEnabled
);
   // All state of the device end
   typedef struct packed {
      logic [3:0] cause; // Reset cause flags
      logic pinKeep; // Pin and logic-array retention select
      logic analogKeep; // Analog die retention select
      rcr_pkg::rcr_lock_t lock; // Unlock sequence position
      logic [15:0] rdata; // Read data
      logic rvalid; // Read answer strobe
      logic [35:0] wdogCount; // Watchdog counter
      logic wdogOn; // Watchdog enabled
      logic sysRst; // System reset pulse
      logic retRst; // Reset of retained state
      logic pinRst; // Pin and logic-array reset
      logic anaRst; // Analog die reset
      logic sramOk; // SRAM contents valid
      logic pending; // Internal reset request pending
      logic [1:0] pendKind; // 2: soft, 3: watchdog
   } rcr_state_t;
   rcr_state_t st;
   rcr_state_t next_st;
   logic softReq; // Core reset request with key
   logic wdogFire; // Watchdog timeout
   logic hardReset; // Pin or power-on reset
   // Software, watchdog and hard reset decode
   always_comb begin
      softReq = bus.coreResetWrite && (bus.coreResetData[31:rcr_pkg::KEY_SHIFT] == rcr_pkg::CORE_RESET_KEY);
      wdogFire = st.wdogOn && (st.wdogCount == 36'(WdogTimeoutCycles - 1));
      hardReset = !powerOnReset_n || !pinReset_n || !rst_n;
   end
   // Next-state logic
   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      next_st.sysRst = 1'b0;
      next_st.retRst = 1'b0;
      next_st.pinRst = 1'b0;
      next_st.anaRst = 1'b0;
      // Watchdog counts while enabled
      if (watchdogDisable) begin
         next_st.wdogOn = 1'b0;
         next_st.wdogCount = '0;
      end else if (watchdogKick || wdogFire) begin
         next_st.wdogCount = '0;
      end else if (st.wdogOn) begin
         next_st.wdogCount = st.wdogCount + 36'h1;
      end
      // Bus writes
      if (bus.busWrite) begin
         if (bus.busAddr == rcr_pkg::RETENTION_UNLOCK_KEY_ADDR) begin
            // Key sequence tracking
            if (bus.busWdata == rcr_pkg::UNLOCK_KEY_FIRST) begin
               next_st.lock = rcr_pkg::RCR_HALF;
            end else if (bus.busWdata == rcr_pkg::UNLOCK_KEY_SECOND && st.lock == rcr_pkg::RCR_HALF) begin
               next_st.lock = rcr_pkg::RCR_OPEN;
            end else begin
               next_st.lock = rcr_pkg::RCR_LOCKED;
            end
         end else if (bus.busAddr == rcr_pkg::PIN_RETENTION_CONFIG_ADDR) begin
            // Accepted only when open, then relock
            if (st.lock == rcr_pkg::RCR_OPEN) begin
               next_st.pinKeep = bus.busWdata[rcr_pkg::KEEP_STATE_BIT];
            end
            next_st.lock = rcr_pkg::RCR_LOCKED;
         end else begin
            next_st.lock = rcr_pkg::RCR_LOCKED;
            if (bus.busAddr == rcr_pkg::ANALOG_DIE_RETENTION_CONFIG_ADDR) begin
               next_st.analogKeep = bus.busWdata[rcr_pkg::KEEP_STATE_BIT];
            end else if (bus.busAddr == rcr_pkg::RESET_CAUSE_STATUS_ADDR) begin
               next_st.cause = st.cause & ~bus.busWdata[3:0];
            end
         end
      end
      // Bus reads
      if (bus.busRead) begin
         next_st.rvalid = 1'b1;
         if (bus.busAddr == rcr_pkg::PIN_RETENTION_CONFIG_ADDR) begin
            next_st.rdata = {15'h0000, st.pinKeep};
         end else if (bus.busAddr == rcr_pkg::RETENTION_UNLOCK_KEY_ADDR) begin
            next_st.rdata = {14'h0000, st.lock};
         end else if (bus.busAddr == rcr_pkg::RESET_CAUSE_STATUS_ADDR) begin
            next_st.rdata = {12'h000, st.cause};
         end else if (bus.busAddr == rcr_pkg::ANALOG_DIE_RETENTION_CONFIG_ADDR) begin
            next_st.rdata = {15'h0000, st.analogKeep};
         end else begin
            next_st.rdata = 16'h0000;
         end
      end
      // Soft reset request latched, applied next cycle
      if (softReq || wdogFire) begin
         next_st.pending = 1'b1;
         next_st.pendKind = softReq ? 2'h2 : 2'h3;
      end
      if (st.pending) begin
         next_st.pending = 1'b0;
         next_st.sysRst = 1'b1;
         next_st.lock = rcr_pkg::RCR_LOCKED;
         next_st.wdogOn = 1'b1;
         next_st.wdogCount = '0;
         next_st.rvalid = 1'b0;
         // Set wins over any clear this cycle
         if (st.pendKind == 2'h2) begin
            next_st.cause[rcr_pkg::SOFTWARE_RESET_BIT] = 1'b1;
         end else begin
            next_st.cause[rcr_pkg::WATCHDOG_RESET_BIT] = 1'b1;
         end
         next_st.pinRst = st.pinKeep;
         next_st.anaRst = st.analogKeep;
      end
      // Hard resets override most state; power-on also replaces the cause flags
      if (hardReset) begin
         next_st.pinKeep = 1'b0;
         next_st.analogKeep = 1'b0;
         next_st.lock = rcr_pkg::RCR_LOCKED;
         next_st.rdata = rcr_pkg::REG_RESET;
         next_st.rvalid = 1'b0;
         next_st.wdogOn = 1'b1;
         next_st.wdogCount = '0;
         next_st.pending = 1'b0;
         next_st.pendKind = 2'h0;
         next_st.sysRst = 1'b1;
         next_st.retRst = 1'b1;
         next_st.pinRst = 1'b1;
         next_st.anaRst = 1'b1;
         if (!powerOnReset_n || !rst_n) begin
            next_st.cause = 4'h1 << rcr_pkg::POWER_ON_RESET_BIT;
            next_st.sramOk = 1'b0;
         end else begin
            next_st.cause[rcr_pkg::PIN_RESET_BIT] = 1'b1;
         end
      end else if (st.sysRst && !st.pending) begin
         next_st.sramOk = 1'b1;
      end
   end
   // State register
   always_ff @(posedge ref_clk) begin
      st <= next_st;
   end
   // Outputs straight from state
   assign systemReset = st.sysRst;
   assign retainedReset = st.retRst;
   assign pinLogicReset = st.pinRst;
   assign analogDieReset = st.anaRst;
   assign sramValid = st.sramOk;
   assign watchdogEnabled = st.wdogOn;
   assign bus.busRdata = st.rdata;
   assign bus.busRvalid = st.rvalid;
endmodule : rcr_reset_unit

// >>> rtl/rcr_pkg.sv
// Package with register map, keys and timing constants of the reset unit
package rcr_pkg;
   localparam logic [31:0] PIN_RETENTION_CONFIG_ADDR = 32'h4000_2408; // Pin and logic-array retention
   localparam logic [31:0] RETENTION_UNLOCK_KEY_ADDR = 32'h4000_240c; // Unlock key register
   localparam logic [31:0] RESET_CAUSE_STATUS_ADDR = 32'h4000_2440; // Reset cause flags, W1C
   localparam logic [31:0] ANALOG_DIE_RETENTION_CONFIG_ADDR = 32'h4008_2c34; // Analog die retention
   localparam logic [15:0] REG_RESET = 16'h0000; // Reset value of the read data register
   localparam logic [15:0] UNLOCK_KEY_FIRST = 16'h2009; // First unlock word
   localparam logic [15:0] UNLOCK_KEY_SECOND = 16'h0426; // Second unlock word
   localparam logic [15:0] CORE_RESET_KEY = 16'h05fa; // Key in upper half of core reset control
   localparam int KEY_SHIFT = 16; // Position of the core reset key
   localparam int SOFTWARE_RESET_BIT = 3; // Cause flag positions
   localparam int WATCHDOG_RESET_BIT = 2;
   localparam int PIN_RESET_BIT = 1;
   localparam int POWER_ON_RESET_BIT = 0;
   localparam int KEEP_STATE_BIT = 0; // Retention select bit in both configs
   localparam longint WDOG_TIMEOUT_S = 32; // Default watchdog timeout, seconds
   localparam longint CLOCK_HZ = 100_000_000; // ref_clk rate
   localparam longint WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_S * CLOCK_HZ; // Timeout in cycles
   // Unlock sequence states
   typedef enum logic [1:0] {RCR_LOCKED, RCR_HALF, RCR_OPEN} rcr_lock_t;
endpackage : rcr_pkg

// >>> rtl/rcr_if.sv
// Interface joining the reset unit and the core / bus side
`timescale 1ns/100ps
interface rcr_if;
   logic busWrite; // Bus write strobe, one cycle
   logic busRead; // Bus read strobe, one cycle
   logic [31:0] busAddr; // Byte address
   logic [15:0] busWdata; // Write data
   logic [15:0] busRdata; // Read data, registered
   logic busRvalid; // Read data valid, one cycle
   logic coreResetWrite; // Core writes reset control register
   logic [31:0] coreResetData; // Full word written to that register
   modport device (input busWrite, busRead, busAddr, busWdata, coreResetWrite, coreResetData,
                   output busRdata, busRvalid);
   modport host (output busWrite, busRead, busAddr, busWdata, coreResetWrite, coreResetData,
                 input busRdata, busRvalid);
endinterface : rcr_if

// >>> rtl/rcr_core_side.sv
// Far end: core reset requests and software register accesses
`timescale 1ns/100ps
module rcr_core_side (
   input wire logic ref_clk,
   input wire logic rst_n,
   rcr_if.host bus,
   input wire logic reqWrite,
   input wire logic reqRead,
   input wire logic [31:0] reqAddr,
   input wire logic [15:0] reqData,
   input wire logic reqUnlockConfig,
   input wire logic reqSoftReset,
   output logic reqBusy,
   output logic [15:0] readData,
   output logic readValid
);
   typedef enum logic [1:0] {RCR_IDLE, RCR_KEY2, RCR_CFG} rcr_seq_t;
   // All state of the far end
   typedef struct packed {
      rcr_seq_t seq; // Unlock sequence step
      logic [15:0] cfgData; // Config value to write
      logic wr; // Bus write strobe
      logic rd; // Bus read strobe
      logic [31:0] addr; // Bus address
      logic [15:0] wdata; // Bus data
      logic coreWr; // Core reset write
      logic [31:0] coreData; // Core reset word
      logic [15:0] rdata; // Captured read data
      logic rvalid; // Read valid
   } rcr_host_t;
   rcr_host_t st;
   rcr_host_t next_st;
   // Sequencing of requests
   always_comb begin
      next_st = st;
      next_st.wr = 1'b0;
      next_st.rd = 1'b0;
      next_st.coreWr = 1'b0;
      next_st.rvalid = bus.busRvalid;
      if (bus.busRvalid) begin
         next_st.rdata = bus.busRdata;
      end
      case (st.seq)
         RCR_KEY2: begin
            next_st.wr = 1'b1;
            next_st.addr = rcr_pkg::RETENTION_UNLOCK_KEY_ADDR;
            next_st.wdata = rcr_pkg::UNLOCK_KEY_SECOND;
            next_st.seq = RCR_CFG;
         end
         RCR_CFG: begin
            next_st.wr = 1'b1;
            next_st.addr = rcr_pkg::PIN_RETENTION_CONFIG_ADDR;
            next_st.wdata = st.cfgData;
            next_st.seq = RCR_IDLE;
         end
         default: begin
            if (reqUnlockConfig) begin
               next_st.wr = 1'b1;
               next_st.addr = rcr_pkg::RETENTION_UNLOCK_KEY_ADDR;
               next_st.wdata = rcr_pkg::UNLOCK_KEY_FIRST;
               next_st.cfgData = reqData;
               next_st.seq = RCR_KEY2;
            end else if (reqSoftReset) begin
               next_st.coreWr = 1'b1;
               next_st.coreData = {rcr_pkg::CORE_RESET_KEY, 16'h0004};
            end else if (reqWrite || reqRead) begin
               next_st.wr = reqWrite;
               next_st.rd = reqRead && !reqWrite;
               next_st.addr = reqAddr;
               next_st.wdata = reqData;
            end
         end
      endcase
      if (!rst_n) begin
         next_st = '0;
         next_st.seq = RCR_IDLE;
      end
   end
   // State register
   always_ff @(posedge ref_clk) begin
      st <= next_st;
   end
   assign reqBusy = (st.seq != RCR_IDLE);
   assign readData = st.rdata;
   assign readValid = st.rvalid;
   assign bus.busWrite = st.wr;
   assign bus.busRead = st.rd;
   assign bus.busAddr = st.addr;
   assign bus.busWdata = st.wdata;
   assign bus.coreResetWrite = st.coreWr;
   assign bus.coreResetData = st.coreData;
endmodule : rcr_core_side

// >>> test/rcr_checker.sv
// Checker of the bus and core reset signals between the two ends
`timescale 1ns/100ps
module rcr_checker (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [31:0] busAddr,
   input wire logic [15:0] busWdata,
   input wire logic [15:0] busRdata,
   input wire logic busRvalid,
   input wire logic coreResetWrite,
   input wire logic [31:0] coreResetData,
   input wire logic systemReset
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [31:0] pa; // Address seen at the previous edge
   // Remember the address that a read answer belongs to
   always_ff @(posedge ref_clk) begin
      pa <= busAddr;
   end
   // Key words on the bus
   sequence s_key1;
      busWrite && busAddr == rcr_pkg::RETENTION_UNLOCK_KEY_ADDR && busWdata == rcr_pkg::UNLOCK_KEY_FIRST;
   endsequence
   sequence s_key2;
      busWrite && busAddr == rcr_pkg::RETENTION_UNLOCK_KEY_ADDR && busWdata == rcr_pkg::UNLOCK_KEY_SECOND;
   endsequence
   property p_walk; s_key1 ##1 s_key2 |=> busWrite && busAddr == rcr_pkg::PIN_RETENTION_CONFIG_ADDR; endproperty
   a_walk: assert property (p_walk) else $error("config write not right after keys");
   property p_soft; coreResetWrite && coreResetData[31:16] == rcr_pkg::CORE_RESET_KEY |-> ##2 systemReset; endproperty
   a_soft: assert property (p_soft) else $error("software reset missing");
   property p_rvalid; busRead |=> busRvalid; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer missing");
   property p_noread; !busRead |=> !busRvalid; endproperty
   a_noread: assert property (p_noread) else $error("read answer without read");
   property p_stat; busRvalid && pa == rcr_pkg::RESET_CAUSE_STATUS_ADDR |-> busRdata[15:4] == 12'h000; endproperty
   a_stat: assert property (p_stat) else $error("status reserved bits set");
   property p_pin; busRvalid && pa == rcr_pkg::PIN_RETENTION_CONFIG_ADDR |-> busRdata[15:1] == 15'h0000; endproperty
   a_pin: assert property (p_pin) else $error("pin config upper bits set");
   property p_ana;
      busRvalid && pa == rcr_pkg::ANALOG_DIE_RETENTION_CONFIG_ADDR |-> busRdata[15:1] == 15'h0000;
   endproperty
   a_ana: assert property (p_ana) else $error("analog config upper bits set");
   property p_key; busRvalid && pa == rcr_pkg::RETENTION_UNLOCK_KEY_ADDR |-> busRdata <= 16'h0002; endproperty
   a_key: assert property (p_key) else $error("key readback out of range");
endmodule : rcr_checker

// >>> test/reset_cause_and_retention_test.sv
// Self-checking bench driving the core side and the reset inputs
`timescale 1ns/100ps
module reset_cause_and_retention_test;
   localparam logic [31:0] ST = rcr_pkg::RESET_CAUSE_STATUS_ADDR;
   localparam logic [31:0] PN = rcr_pkg::PIN_RETENTION_CONFIG_ADDR;
   localparam logic [31:0] KY = rcr_pkg::RETENTION_UNLOCK_KEY_ADDR;
   localparam logic [31:0] AN = rcr_pkg::ANALOG_DIE_RETENTION_CONFIG_ADDR;
   logic ref_clk = 1'b0, rst_n = 1'b0, powerOnReset_n = 1'b1, pinReset_n = 1'b1;
   logic watchdogDisable = 1'b0, watchdogKick = 1'b0, reqWrite = 1'b0, reqRead = 1'b0;
   logic reqUnlockConfig = 1'b0, reqSoftReset = 1'b0, reqBusy, readValid;
   logic [31:0] reqAddr = 32'h0000_0000;
   logic [15:0] reqData = 16'h0000, readData;
   logic systemReset, retainedReset, pinLogicReset, analogDieReset, sramValid, watchdogEnabled;
   logic [2:0] seen; // Retained, pin and analog pulses of the last reset
   int err_total = 0, n_compared = 0, nRst = 0, n;
   rcr_if busIf();
   rcr_reset_unit #(.WdogTimeoutCycles(50)) rcr_reset_unit_i (.ref_clk, .rst_n, .bus(busIf.device),
      .powerOnReset_n, .pinReset_n, .watchdogDisable, .watchdogKick, .systemReset, .retainedReset,
      .pinLogicReset, .analogDieReset, .sramValid, .watchdogEnabled);
   rcr_core_side rcr_core_side_i (.ref_clk, .rst_n, .bus(busIf.host), .reqWrite, .reqRead, .reqAddr,
      .reqData, .reqUnlockConfig, .reqSoftReset, .reqBusy, .readData, .readValid);
   rcr_checker rcr_checker_i (.ref_clk, .rst_n, .busWrite(busIf.busWrite), .busRead(busIf.busRead),
      .busAddr(busIf.busAddr), .busWdata(busIf.busWdata), .busRdata(busIf.busRdata),
      .busRvalid(busIf.busRvalid), .coreResetWrite(busIf.coreResetWrite),
      .coreResetData(busIf.coreResetData), .systemReset);
   // Clock
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // Count reset pulses and note their qualifiers
   always @(posedge ref_clk) begin
      if (rst_n && systemReset === 1'b1) begin
         nRst++;
         seen = {retainedReset, pinLogicReset, analogDieReset};
      end
   end
   task automatic conclude;
      if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic fail;
      err_total++;
      $display("BAD %0t wait ran out", $time);
      conclude();
   endtask : fail
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Wait until the core side is free again
   task automatic idle;
      int k;
      for (k = 0; k < 20 && reqBusy !== 1'b0; k++) @(negedge ref_clk);
      if (k == 20) fail();
   endtask : idle
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      reqAddr = a;
      reqData = d;
      reqWrite = 1'b1;
      @(negedge ref_clk) reqWrite = 1'b0;
      idle();
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [15:0] e);
      int k;
      reqAddr = a;
      reqRead = 1'b1;
      @(negedge ref_clk) reqRead = 1'b0;
      for (k = 0; k < 10 && readValid !== 1'b1; k++) @(negedge ref_clk);
      if (k == 10) fail();
      chk(readData, e);
      idle();
   endtask : rd
   // Wait for a new reset pulse
   task automatic waitRst;
      int k;
      for (k = 0; k < 120 && nRst == n; k++) @(negedge ref_clk);
      if (k == 120) fail();
      @(negedge ref_clk);
   endtask : waitRst
   // Main sequence
   initial begin
      repeat (8) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk({15'h0000, watchdogEnabled}, 16'h0001);
      watchdogDisable = 1'b1;
      rd(ST, 16'h0001);
      rd(PN, 16'h0000);
      rd(AN, 16'h0000);
      wr(ST, 16'h0000);
      rd(ST, 16'h0001);
      wr(ST, 16'h0001);
      rd(ST, 16'h0000);
      wr(PN, 16'h0001);
      rd(PN, 16'h0000);
      wr(KY, rcr_pkg::UNLOCK_KEY_FIRST);
      rd(KY, 16'h0001);
      wr(AN, 16'h0000);
      rd(KY, 16'h0000);
      wr(KY, rcr_pkg::UNLOCK_KEY_SECOND);
      wr(PN, 16'h0001);
      rd(PN, 16'h0000);
      reqData = 16'h0001;
      reqUnlockConfig = 1'b1;
      @(negedge ref_clk) reqUnlockConfig = 1'b0;
      idle();
      rd(PN, 16'h0001);
      watchdogDisable = 1'b0;
      n = nRst;
      reqSoftReset = 1'b1;
      @(negedge ref_clk) reqSoftReset = 1'b0;
      waitRst();
      chk({13'h0000, seen}, 16'h0002);
      chk({15'h0000, watchdogEnabled}, 16'h0001);
      rd(PN, 16'h0001);
      rd(ST, 16'h0008);
      wr(ST, 16'h0008);
      wr(AN, 16'h0001);
      rd(AN, 16'h0001);
      n = nRst;
      repeat (6) begin
         repeat (20) @(negedge ref_clk);
         watchdogKick = 1'b1;
         @(negedge ref_clk) watchdogKick = 1'b0;
      end
      chk(16'(nRst - n), 16'h0000);
      waitRst();
      watchdogDisable = 1'b1;
      chk({13'h0000, seen}, 16'h0003);
      rd(ST, 16'h0004);
      wr(ST, 16'h0004);
      pinReset_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      pinReset_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk({12'h000, seen, sramValid}, 16'h000f);
      rd(ST, 16'h0002);
      rd(PN, 16'h0000);
      rd(AN, 16'h0000);
      powerOnReset_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk({15'h0000, sramValid}, 16'h0000);
      powerOnReset_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      rd(ST, 16'h0001);
      conclude();
   end
endmodule : reset_cause_and_retention_test
